// ==== hdl/asc_ctrl_top.sv ====
// asc_ctrl_top.sv: control registers, transmitter sequencing and interrupt gating of an async serial unit
// assumes: receiver core and status flags live outside and run on clk_in; data buffer writes arrive as strobes
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "asc_regs.svh"

module asc_ctrl_top #(
  parameter int unsigned BIT_DIV = `ASC_BIT_DIV // clocks per bit time
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register port
  input wire asc_pkg::asc_addr_t reg_addr_in,
  input wire asc_pkg::asc_byte_t reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output asc_pkg::asc_byte_t reg_rdata_out,
  // data buffer side
  input wire asc_pkg::asc_byte_t tx_data_in,
  input wire logic tx_load_in,
  input wire logic rx_char_valid_in,
  input wire logic [8:0] rx_char_in,
  input wire logic rx_idle_in,
  // receiver flags from the status logic
  input wire logic rx_buffer_full_flag_in,
  input wire logic idle_flag_in,
  input wire logic overrun_flag_in,
  input wire logic noise_flag_in,
  input wire logic stop_bit_error_flag_in,
  // serial line
  output logic tx_line_out,
  // transmitter flags
  output logic tx_buffer_empty_flag_out,
  output logic tx_done_flag_out,
  // settings for the receiver core
  output logic module_on_out,
  output logic char9_out,
  output logic idle_count_start_select_out,
  output logic parity_on_out,
  output logic parity_odd_select_out,
  output logic rx_on_out,
  output logic rx_standby_out,
  // interrupt requests
  output logic tx_irq_out,
  output logic rx_irq_out,
  output logic err_irq_out
);
  import asc_pkg::*;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // parity over the masked slots; odd adds one so the total count is odd
  function automatic logic asc_parity(input logic [8:0] v, input logic [8:0] mask, input logic odd);
    asc_parity = (^(v & mask)) ^ odd;
  endfunction

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic module_on_q, char9_q, wake_addr_q, idle_start_q, parity_on_q, parity_odd_q;
  logic tx_empty_ie_q, tx_done_ie_q, rx_full_ie_q, idle_ie_q;
  logic tx_on_q, rx_on_q, rx_standby_q, send_break_q;
  logic rx_ninth_q, tx_ninth_q, dma_rx_q, dma_tx_q, overrun_ie_q, noise_ie_q, framing_ie_q;
  logic wr_one, wr_two, wr_three; // write strobes per register
  logic wake_hit; // selected wakeup condition seen
  logic rx_msb; // most significant received slot

  // address decode
  always_comb begin
    wr_one = 1'b0;
    wr_two = 1'b0;
    wr_three = 1'b0;
    if (reg_wr_in && reg_addr_in == `ASC_OFS_CTRL_ONE) begin
      wr_one = 1'b1;
    end else if (reg_wr_in && reg_addr_in == `ASC_OFS_CTRL_TWO) begin
      wr_two = 1'b1;
    end else if (reg_wr_in && reg_addr_in == `ASC_OFS_CTRL_THREE) begin
      wr_three = 1'b1;
    end
  end

  // format and enable register
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      module_on_q <= `ASC_CTRL_RESET;
      char9_q <= `ASC_CTRL_RESET;
      wake_addr_q <= `ASC_CTRL_RESET;
      idle_start_q <= `ASC_CTRL_RESET;
      parity_on_q <= `ASC_CTRL_RESET;
      parity_odd_q <= `ASC_CTRL_RESET;
    end else if (wr_one) begin
      module_on_q <= reg_wdata_in[`ASC_C1_MODULE_ON];
      char9_q <= reg_wdata_in[`ASC_C1_CHAR9];
      wake_addr_q <= reg_wdata_in[`ASC_C1_WAKE_ADDR];
      idle_start_q <= reg_wdata_in[`ASC_C1_IDLE_START];
      parity_on_q <= reg_wdata_in[`ASC_C1_PARITY_ON];
      parity_odd_q <= reg_wdata_in[`ASC_C1_PARITY_ODD];
    end
  end

  // wakeup: address mark is a one in the top slot, otherwise an idle character
  assign rx_msb = char9_q ? rx_char_in[8] : rx_char_in[7];
  assign wake_hit = wake_addr_q ? (rx_char_valid_in && rx_msb) : rx_idle_in;

  // interrupt enables and transmitter/receiver controls
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_empty_ie_q <= `ASC_CTRL_RESET;
      tx_done_ie_q <= `ASC_CTRL_RESET;
      rx_full_ie_q <= `ASC_CTRL_RESET;
      idle_ie_q <= `ASC_CTRL_RESET;
      tx_on_q <= `ASC_CTRL_RESET;
      rx_on_q <= `ASC_CTRL_RESET;
      send_break_q <= `ASC_CTRL_RESET;
    end else if (wr_two) begin
      tx_empty_ie_q <= reg_wdata_in[`ASC_C2_TX_EMPTY_IE];
      tx_done_ie_q <= reg_wdata_in[`ASC_C2_TX_DONE_IE];
      rx_full_ie_q <= reg_wdata_in[`ASC_C2_RX_FULL_IE];
      idle_ie_q <= reg_wdata_in[`ASC_C2_IDLE_IE];
      tx_on_q <= reg_wdata_in[`ASC_C2_TX_ON];
      rx_on_q <= reg_wdata_in[`ASC_C2_RX_ON];
      send_break_q <= reg_wdata_in[`ASC_C2_SEND_BREAK];
    end
  end

  // standby: a software write wins over the wakeup clear in the same cycle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_standby_q <= `ASC_CTRL_RESET;
    end else if (wr_two) begin
      rx_standby_q <= reg_wdata_in[`ASC_C2_RX_STANDBY];
    end else if (wake_hit) begin
      rx_standby_q <= 1'b0;
    end
  end

  // error enables and dma bits; dma bits only store, nothing here consumes them
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dma_rx_q <= `ASC_CTRL_RESET;
      dma_tx_q <= `ASC_CTRL_RESET;
      overrun_ie_q <= `ASC_CTRL_RESET;
      noise_ie_q <= `ASC_CTRL_RESET;
      framing_ie_q <= `ASC_CTRL_RESET;
    end else if (wr_three) begin
      dma_rx_q <= reg_wdata_in[`ASC_C3_DMA_RX];
      dma_tx_q <= reg_wdata_in[`ASC_C3_DMA_TX];
      overrun_ie_q <= reg_wdata_in[`ASC_C3_OVERRUN_IE];
      noise_ie_q <= reg_wdata_in[`ASC_C3_NOISE_IE];
      framing_ie_q <= reg_wdata_in[`ASC_C3_FRAMING_IE];
    end
  end

  // received ninth bit keeps its value across reset, so it has no reset branch
  always_ff @(posedge clk_in) begin
    if (rx_char_valid_in) begin
      rx_ninth_q <= rx_msb;
    end
  end

  // ---------------------------------------------------------------
  // register read port: data stand in the cycle after the strobe only
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in && reg_addr_in == `ASC_OFS_CTRL_ONE) begin
      reg_rdata_out <= {1'b0, module_on_q, 1'b0, char9_q, wake_addr_q, idle_start_q, parity_on_q, parity_odd_q};
    end else if (reg_rd_in && reg_addr_in == `ASC_OFS_CTRL_TWO) begin
      reg_rdata_out <= {tx_empty_ie_q, tx_done_ie_q, rx_full_ie_q, idle_ie_q,
                        tx_on_q, rx_on_q, rx_standby_q, send_break_q};
    end else if (reg_rd_in && reg_addr_in == `ASC_OFS_CTRL_THREE) begin
      reg_rdata_out <= {rx_ninth_q, tx_ninth_q, dma_rx_q, dma_tx_q, overrun_ie_q, noise_ie_q, framing_ie_q, 1'b0};
    end else begin
      reg_rdata_out <= 8'h00; // unmapped address or no read
    end
  end

  // ---------------------------------------------------------------
  // bit-time divider: the generator stops while the module is off
  // ---------------------------------------------------------------
  logic [15:0] div_q; // clocks within the bit time
  logic tick_q; // one-cycle pulse per bit time

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (!module_on_q) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 16'(BIT_DIV - 1)) begin
      div_q <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transmitter sequencing
  // ---------------------------------------------------------------
  asc_byte_t txbuf_q; // data buffer byte waiting for the shifter
  logic [10:0] shift_q; // bit 0 drives the line, ones shift in behind
  logic [3:0] cnt_q; // bits left in the current character
  asc_frame_t frame_q; // kind of character now on the line
  logic pre_pend_q, brk_pend_q, tx_empty_q, tx_done_q;
  logic tx_rise; // transmitter enable written from off to on
  logic at_gap; // a new character may start on this tick
  logic ld_brk, ld_mark, ld_pre, ld_data;
  logic [8:0] slots; // data slots with parity applied
  logic [10:0] data_frame;
  logic [3:0] frame_len;

  assign tx_rise = wr_two && reg_wdata_in[`ASC_C2_TX_ON] && !tx_on_q;
  assign at_gap = tick_q && cnt_q <= 4'h1;
  assign frame_len = char9_q ? `ASC_FRAME_LEN_9 : `ASC_FRAME_LEN_8;

  // load choice: break beats the post-break one, the preamble and data; a frame in flight always finishes
  assign ld_brk = at_gap && tx_on_q && (send_break_q || brk_pend_q);
  assign ld_mark = at_gap && !ld_brk && frame_q == ASC_FR_BREAK && cnt_q == 4'h1;
  assign ld_pre = at_gap && tx_on_q && !ld_brk && !ld_mark && pre_pend_q;
  assign ld_data = at_gap && tx_on_q && !ld_brk && !ld_mark && !pre_pend_q && !tx_empty_q;

  // frame image: start bit at 0, slots next, stop after; parity takes the top slot
  always_comb begin
    slots = {tx_ninth_q, txbuf_q};
    if (parity_on_q && char9_q) begin
      slots[8] = asc_parity(slots, 9'h0FF, parity_odd_q);
    end else if (parity_on_q) begin
      slots[7] = asc_parity(slots, 9'h07F, parity_odd_q);
    end
    data_frame = char9_q ? {1'b1, slots, 1'b0} : {2'b11, slots[7:0], 1'b0};
  end

  // buffer byte has no reset, like the data buffer it stands for
  always_ff @(posedge clk_in) begin
    if (tx_load_in) begin
      txbuf_q <= tx_data_in;
    end
  end

  // ninth transmit bit is stored without reset
  always_ff @(posedge clk_in) begin
    if (wr_three) begin
      tx_ninth_q <= reg_wdata_in[`ASC_C3_TX_NINTH];
    end
  end

  // shifter and character counter
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shift_q <= 11'h7FF;
      cnt_q <= 4'h0;
      frame_q <= ASC_FR_NONE;
    end else if (ld_brk) begin
      shift_q <= 11'h000; // back to back breaks leave no ones between
      cnt_q <= frame_len;
      frame_q <= ASC_FR_BREAK;
    end else if (ld_mark) begin
      shift_q <= 11'h7FF;
      cnt_q <= `ASC_MARK_LEN;
      frame_q <= ASC_FR_IDLE;
    end else if (ld_pre) begin
      shift_q <= 11'h7FF;
      cnt_q <= frame_len;
      frame_q <= ASC_FR_IDLE;
    end else if (ld_data) begin
      shift_q <= data_frame;
      cnt_q <= frame_len;
      frame_q <= ASC_FR_DATA;
    end else if (tick_q && cnt_q != 4'h0) begin
      shift_q <= {1'b1, shift_q[10:1]}; // line returns high after the last bit
      cnt_q <= cnt_q - 4'h1;
      frame_q <= (cnt_q == 4'h1) ? ASC_FR_NONE : frame_q;
    end
  end

  // pending preamble and pending break; a new request wins over the consume
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
    end else begin
      if (tx_rise) begin
        pre_pend_q <= 1'b1;
      end else if (ld_pre || ld_brk) begin
        pre_pend_q <= 1'b0; // a break stands in for the preamble
      end
      if (wr_two && reg_wdata_in[`ASC_C2_SEND_BREAK] && !send_break_q) begin
        brk_pend_q <= 1'b1;
      end else if (ld_brk) begin
        brk_pend_q <= 1'b0;
      end
    end
  end

  // transmitter flags: module off forces both set
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_empty_q <= 1'b1;
      tx_done_q <= 1'b1;
    end else begin
      if (!module_on_q || ld_data) begin
        tx_empty_q <= 1'b1;
      end else if (tx_load_in) begin
        tx_empty_q <= 1'b0;
      end
      tx_done_q <= !module_on_q || (tx_empty_q && cnt_q == 4'h0 && !pre_pend_q && !brk_pend_q && !send_break_q);
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests, registered so the outputs come from flops
  // ---------------------------------------------------------------
  logic tx_irq_q, rx_irq_q, err_irq_q;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
      err_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= module_on_q && ((tx_empty_q && tx_empty_ie_q) || (tx_done_q && tx_done_ie_q));
      rx_irq_q <= !rx_standby_q && ((rx_buffer_full_flag_in && rx_full_ie_q) || (idle_flag_in && idle_ie_q));
      err_irq_q <= (overrun_flag_in && overrun_ie_q) || (noise_flag_in && noise_ie_q)
                   || (stop_bit_error_flag_in && framing_ie_q);
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign tx_line_out = shift_q[0];
  assign tx_buffer_empty_flag_out = tx_empty_q;
  assign tx_done_flag_out = tx_done_q;
  assign module_on_out = module_on_q;
  assign char9_out = char9_q;
  assign idle_count_start_select_out = idle_start_q;
  assign parity_on_out = parity_on_q;
  assign parity_odd_select_out = parity_odd_q;
  assign rx_on_out = rx_on_q;
  assign rx_standby_out = rx_standby_q;
  assign tx_irq_out = tx_irq_q;
  assign rx_irq_out = rx_irq_q;
  assign err_irq_out = err_irq_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_break_ends;
    tick_q && frame_q == ASC_FR_BREAK && cnt_q == 4'h1 && !send_break_q && !brk_pend_q;
  endsequence

  a_tx_empty_gate: assert property (module_on_q && tx_empty_q && tx_empty_ie_q |=> tx_irq_out)
    else $error("empty flag enabled but no transmitter irq");
  a_tx_done_gate: assert property (module_on_q && tx_done_q && tx_done_ie_q |=> tx_irq_out)
    else $error("done flag enabled but no transmitter irq");
  a_rx_full_gate: assert property (rx_buffer_full_flag_in && rx_full_ie_q && !rx_standby_q |=> rx_irq_out)
    else $error("full flag enabled but no receiver irq");
  a_idle_line_gate: assert property (idle_flag_in && idle_ie_q && !rx_standby_q |=> rx_irq_out)
    else $error("idle flag enabled but no receiver irq");
  a_standby_mutes_rx: assert property (rx_standby_q |=> !rx_irq_out)
    else $error("receiver irq raised in standby");
  a_noise_err_gate: assert property (noise_flag_in && noise_ie_q |=> err_irq_out)
    else $error("noise flag enabled but no error irq");
  a_module_off_flags: assert property ($fell(module_on_q) |=> tx_empty_q && tx_done_q && !tx_irq_out)
    else $error("module off did not set empty and done");
  a_preamble_queued: assert property (tx_rise |=> pre_pend_q)
    else $error("enable rise did not queue a preamble");
  a_break_line_low: assert property (frame_q == ASC_FR_BREAK && cnt_q != 4'h0 |-> !tx_line_out)
    else $error("line high during break character");
  a_break_then_one: assert property (s_break_ends |=> frame_q == ASC_FR_IDLE ##0 tx_line_out)
    else $error("no one after break character");
  a_ninth_capture: assert property (rx_char_valid_in |=> rx_ninth_q == $past(rx_msb))
    else $error("received ninth bit not captured");

endmodule
`default_nettype wire

// ==== hdl/asc_regs.svh ====
// asc_regs.svh: offsets, field positions, reset values and timing counts of the serial control block
// assumes: included by its bare name from the package and from the design file
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// ---------------------------------------------------------------
// register offsets (2-bit register port address)
// ---------------------------------------------------------------
`define ASC_OFS_CTRL_ONE 2'h0
`define ASC_OFS_CTRL_TWO 2'h1
`define ASC_OFS_CTRL_THREE 2'h2

// ---------------------------------------------------------------
// serial_control_one fields
// ---------------------------------------------------------------
`define ASC_C1_MODULE_ON 6
`define ASC_C1_CHAR9 4
`define ASC_C1_WAKE_ADDR 3
`define ASC_C1_IDLE_START 2
`define ASC_C1_PARITY_ON 1
`define ASC_C1_PARITY_ODD 0

// ---------------------------------------------------------------
// serial_control_two fields
// ---------------------------------------------------------------
`define ASC_C2_TX_EMPTY_IE 7
`define ASC_C2_TX_DONE_IE 6
`define ASC_C2_RX_FULL_IE 5
`define ASC_C2_IDLE_IE 4
`define ASC_C2_TX_ON 3
`define ASC_C2_RX_ON 2
`define ASC_C2_RX_STANDBY 1
`define ASC_C2_SEND_BREAK 0

// ---------------------------------------------------------------
// serial_control_three fields
// ---------------------------------------------------------------
`define ASC_C3_RX_NINTH 7
`define ASC_C3_TX_NINTH 6
`define ASC_C3_DMA_RX 5
`define ASC_C3_DMA_TX 4
`define ASC_C3_OVERRUN_IE 3
`define ASC_C3_NOISE_IE 2
`define ASC_C3_FRAMING_IE 1

// ---------------------------------------------------------------
// reset values, frame sizes, timing
// ---------------------------------------------------------------
`define ASC_CTRL_RESET 1'b0
`define ASC_FRAME_LEN_8 4'hA
`define ASC_FRAME_LEN_9 4'hB
`define ASC_MARK_LEN 4'h1
`define ASC_BIT_DIV 16

`endif

// ==== hdl/asc_pkg.sv ====
// asc_pkg.sv: types shared by the serial control block
// assumes: asc_regs.svh is on the include path
`include "asc_regs.svh"

package asc_pkg;

  // register port address
  typedef logic [1:0] asc_addr_t;

  // register data byte
  typedef logic [7:0] asc_byte_t;

  // kind of character the transmitter is shifting out
  typedef enum logic [1:0] {
    ASC_FR_NONE,
    ASC_FR_DATA,
    ASC_FR_IDLE,
    ASC_FR_BREAK
  } asc_frame_t;

endpackage

// ==== verification/asc_remote_node.sv ====
// asc_remote_node.sv: behavioural remote serial node listening on the transmit line
// assumes: line idles high, one bit lasts BIT_DIV clocks, nine_in picks the frame length
`timescale 1ns/1ps
`default_nettype none

module asc_remote_node #(
  parameter int BIT_DIV = 8 // clocks per bit time
) (
  // clock
  input wire logic clk_in,
  // serial line and format
  input wire logic line_in,
  input wire logic nine_in,
  // decoded frame: data slots first, stop bit last
  output logic [9:0] frame_out,
  output logic got_out
);
  logic [9:0] f; // frame being assembled
  // ------------------------------------------------------------
  // start edge, then one sample in the middle of each bit
  // ------------------------------------------------------------
  initial begin
    got_out = 1'b0;
    frame_out = '0;
    forever begin
      @(negedge line_in);
      repeat (BIT_DIV / 2) @(posedge clk_in); // centre of start bit
      f = '0;
      for (int i = 0; i < (nine_in ? 10 : 9); i++) begin
        repeat (BIT_DIV) @(posedge clk_in);
        f[i] = line_in;
      end
      frame_out <= f;
      got_out <= 1'b1;
      @(posedge clk_in);
      got_out <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// ==== verification/tb_async_serial_control_regs.sv ====
// tb_async_serial_control_regs.sv: self-checking bench of the serial control block
// assumes: asc_pkg and asc_ctrl_top compiled first; remote node decodes the transmit line
`timescale 1ns/1ps
`default_nettype none

module tb_async_serial_control_regs;
  import asc_pkg::*;
  localparam int BD = 8; // short bit time keeps the run brief
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  asc_addr_t addr = '0;
  asc_byte_t wdata = '0, txd = '0, rdata;
  logic wr = 1'b0, rd = 1'b0, load = 1'b0, cval = 1'b0, idle = 1'b0;
  logic [8:0] rch = '0;
  logic [4:0] fl = '0; // full, idle, overrun, noise, framing
  logic line, empty, done, mon, c9, ics, pon, podd, ron, stby, tirq, rirq, eirq, got;
  logic [9:0] frm;
  logic [31:0] seed = 32'h9DBB4998;
  logic [7:0] c1, c2, c3;
  int failures = 0, samples_checked = 0, n;

  always #2.5 clk_in = ~clk_in;

  asc_ctrl_top #(.BIT_DIV(BD)) u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .tx_data_in(txd),
    .tx_load_in(load), .rx_char_valid_in(cval), .rx_char_in(rch), .rx_idle_in(idle),
    .rx_buffer_full_flag_in(fl[4]), .idle_flag_in(fl[3]), .overrun_flag_in(fl[2]), .noise_flag_in(fl[1]),
    .stop_bit_error_flag_in(fl[0]), .tx_line_out(line), .tx_buffer_empty_flag_out(empty),
    .tx_done_flag_out(done), .module_on_out(mon), .char9_out(c9), .idle_count_start_select_out(ics),
    .parity_on_out(pon), .parity_odd_select_out(podd), .rx_on_out(ron), .rx_standby_out(stby),
    .tx_irq_out(tirq), .rx_irq_out(rirq), .err_irq_out(eirq));

  asc_remote_node #(.BIT_DIV(BD)) u_node (.clk_in(clk_in), .line_in(line), .nine_in(c9),
    .frame_out(frm), .got_out(got));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // expected frame as the node sees it: slots, then stop bit
  function automatic logic [9:0] exp_frame(input logic [7:0] cfg, input logic t8, input logic [7:0] d);
    logic [8:0] s;
    s = {t8, d};
    if (cfg[1] && cfg[4]) s[8] = ^s[7:0] ^ cfg[0];
    if (cfg[1] && !cfg[4]) s[7] = ^s[6:0] ^ cfg[0];
    return cfg[4] ? {1'b1, s} : {2'b01, s[7:0]};
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (e !== g) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask

  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 chk(nm, e & m, rdata & m);
  endtask

  // bounded wait on the line (sel 0) or the node's frame pulse (sel 1)
  task automatic waitfor(input bit sel, input logic v, input int max);
    n = 0;
    while ((sel ? got : line) !== v && n < max) begin
      @(posedge clk_in);
      n++;
    end
    if (n >= max) begin
      chk("wait bound", 10'h000, 10'h001);
      give_verdict;
    end
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tick(10);
    arst_n_in <= 1'b1;
    #1 chk("reset outputs", 10'h380, {line, empty, done, tirq, rirq, eirq, mon, c9, ics, pon});
    // both ninth bits keep no reset value, so they stay out of the ctrl three compare
    for (int a = 0; a < 4; a++) rreg(a[1:0], a == 2 ? 8'h3F : 8'hFF, 8'h00, "reset value");
    wreg(2'h3, 8'hFF);
    rreg(2'h3, 8'hFF, 8'h00, "unmapped");
    // random settings and flags; module switched on before any enable write
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      c1 = 8'h40 | (seed[7:0] & 8'hBF);
      c2 = seed[15:8] & 8'hF6;
      c3 = seed[23:16] & 8'hCF;
      fl <= seed[28:24];
      wreg(2'h0, c1);
      wreg(2'h1, c2);
      wreg(2'h2, c3);
      tick(2);
      rreg(2'h0, 8'hFF, c1 & 8'h5F, "control one");
      rreg(2'h1, 8'hFF, c2, "control two");
      rreg(2'h2, 8'h7F, c3 & 8'h4E, "control three");
      chk("settings", {c1[6], c1[4], c1[2], c1[1], c1[0], c2[2], c2[1]}, {mon, c9, ics, pon, podd, ron, stby});
      chk("irqs", {|c2[7:6], ~c2[1] & |(c2[5:4] & fl[4:3]), |(c3[3:1] & fl[2:0])}, {tirq, rirq, eirq});
    end
    // standby: address mark in both lengths, then idle wakeup
    fl <= 5'h10;
    for (int k = 0; k < 4; k++) begin
      wreg(2'h0, k == 0 ? 8'h48 : k == 3 ? 8'h40 : 8'h58);
      wreg(2'h1, 8'h22);
      tick(2);
      chk("muted rx irq", 10'h000, rirq);
      @(posedge clk_in);
      rch <= k == 0 ? 9'h080 : k == 1 ? 9'h0FF : 9'h100;
      cval <= k != 3;
      idle <= k == 3;
      @(posedge clk_in);
      cval <= 1'b0;
      idle <= 1'b0;
      tick(2);
      chk("standby", k == 1, stby);
      chk("rx irq", k != 1, rirq);
      if (k < 3) rreg(2'h2, 8'h80, {k != 1, 7'h00}, "rx ninth bit");
    end
    // every character format: preamble, then one frame
    fl <= 5'h00;
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      c1 = {3'b010, k[2], 2'b00, k[1], k[0]};
      wreg(2'h0, c1);
      wreg(2'h2, {1'b0, seed[8], 6'h00});
      wreg(2'h1, 8'h00);
      wreg(2'h1, 8'h08);
      @(posedge clk_in);
      txd <= seed[7:0];
      load <= 1'b1;
      @(posedge clk_in);
      load <= 1'b0;
      waitfor(1'b0, 1'b0, 40 * BD);
      chk("preamble", 10'h001, n >= (c1[4] ? 11 : 10) * BD - 3 && n <= (c1[4] ? 12 : 11) * BD);
      // switching the transmitter off mid frame must still deliver the whole frame
      if (k[0] && !k[2]) wreg(2'h1, 8'h00);
      waitfor(1'b1, 1'b1, 14 * BD);
      chk("frame", exp_frame(c1, seed[8], seed[7:0]), frm);
      tick(2 * BD);
    end
    // break held for two frames, then released
    wreg(2'h1, 8'h09);
    waitfor(1'b0, 1'b0, 40 * BD);
    n = 0;
    repeat (20 * BD) begin
      @(posedge clk_in);
      n += line;
    end
    chk("break run", 10'h000, n[9:0]);
    // a byte queued behind the break shows how long the single one lasts
    @(posedge clk_in);
    txd <= seed[15:8];
    load <= 1'b1;
    @(posedge clk_in);
    load <= 1'b0;
    wreg(2'h1, 8'h08);
    waitfor(1'b0, 1'b1, 12 * BD);
    waitfor(1'b0, 1'b0, 2 * BD);
    chk("mark after break", 10'h001, n >= BD - 1 && n <= BD + 1);
    give_verdict;
  end
endmodule

`default_nettype wire
